// ===== design/sdmc_top.sv
// control logic of the dual h-bridge pair motor driver with register access
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sdmc_defs.svh"
module sdmc_top #(
	parameter int WAKE_CYCLES = `SDMC_WAKE_TIME_MS * `SDMC_CLK_FREQ_KHZ,
	parameter int DEAD_CYCLES = (`SDMC_DEAD_TIME_NS + `SDMC_CLK_PERIOD_NS - 1)
	                            / `SDMC_CLK_PERIOD_NS,
	parameter int CHOP_DIV    = `SDMC_CHOP_DIV
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// axi4-lite write address and data
	input  wire logic [7:0]                 awaddr,
	input  wire logic [2:0]                 awprot,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	// axi4-lite write response
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	// axi4-lite read
	input  wire logic [7:0]                 araddr,
	input  wire logic [2:0]                 arprot,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	// control pins, index 0 is the first pair
	input  wire sdmc_pkg::sdmc_pair_pins_t [1:0] pairPins,
	input  wire logic [3:0]                 senseTrip,
	input  wire logic                       chopperRefClock,
	input  wire logic                       wakeRequest,
	input  wire logic                       thermalShutdown,
	input  wire logic                       overcurrentDetect,
	// gate drives, leg 2b is bridge b positive, 2b+1 negative
	output logic [7:0]                      hiGate,
	output logic [7:0]                      loGate,
	// chopper and position status to the analog stage
	output logic [3:0]                      senseMask,
	output logic [3:0]                      decaying,
	output logic [1:0]                      mixedDecay37,
	output logic [1:0]                      positionMonitorOut,
	// open-drain fault pin
	output logic                            faultOut,
	output logic                            faultOe
);

	localparam int WW = $clog2(WAKE_CYCLES + 1);
	localparam int DW = $clog2(CHOP_DIV + 1);

	if (WAKE_CYCLES < 1 || CHOP_DIV < 2) begin : g_badParam
		$error("sdmc_top needs a wake count of one and a divider of two or more");
	end

	// synchronised pins
	logic [19:0]               pinsS;      // accepted pin levels
	sdmc_pkg::sdmc_pair_pins_t pairS [2];  // per pair pins after sync
	logic [3:0]                tripS;      // current sense comparators
	logic                      oscS;       // chopper reference clock level
	logic                      wakeS;      // low-power request released
	logic                      faultS;     // thermal or overcurrent error

	sdmc_pin_sync #(
		.WIDTH(20)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.asyncIn  ({thermalShutdown, overcurrentDetect, wakeRequest, chopperRefClock,
		            senseTrip, pairPins}),
		.stableOut(pinsS)
	);

	// unpack the accepted levels
	assign pairS[0] = pinsS[5:0];
	assign pairS[1] = pinsS[11:6];
	assign tripS    = pinsS[15:12];
	assign oscS     = pinsS[16];
	assign wakeS    = pinsS[17];
	assign faultS   = pinsS[19] | pinsS[18];

	// registers, bus side
	logic [2:0]  ctrl_q;     // drive mode bits and lock
	logic        awHave_q;   // write address held
	logic [7:0]  awAddr_q;   // held write address
	logic        wHave_q;    // write data held
	logic [31:0] wData_q;    // held write data
	logic [3:0]  wStrb_q;    // held byte enables
	logic        bvalid_q;   // write answer pending
	logic [1:0]  bresp_q;    // write answer code
	logic        rvalid_q;   // read answer pending
	logic [31:0] rdata_q;    // read answer data
	logic [1:0]  rresp_q;    // read answer code
	logic [31:0] statusWord; // live status view

	// bus decode
	wire       doWrite  = awHave_q & wHave_q & ~bvalid_q;
	wire       wrCtrl   = (awAddr_q == `SDMC_ADDR_CTRL);
	wire       rdCtrl   = (araddr == `SDMC_ADDR_CTRL);
	wire       rdStatus = (araddr == `SDMC_ADDR_STATUS);
	wire       arTake   = arvalid & ~rvalid_q;
	wire [1:0] dcMode   = ctrl_q[`SDMC_CTRL_DC_LSB +: 2];
	wire       modeLock = ctrl_q[`SDMC_CTRL_LOCK_BIT];

	assign awready = ~awHave_q & ~bvalid_q;
	assign wready  = ~wHave_q & ~bvalid_q;
	assign arready = ~rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;

	// write channel: address and data held in either order, answer after both
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			awHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wHave_q  <= 1'b0;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= `SDMC_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awHave_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHave_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (doWrite) begin
				awHave_q <= 1'b0;
				wHave_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= wrCtrl ? `SDMC_RESP_OKAY : `SDMC_RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// drive mode register, frozen once the lock bit is set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `SDMC_CTRL_RESET;
		end else if (doWrite && wrCtrl && wStrb_q[0] && !modeLock) begin
			ctrl_q <= wData_q[2:0];
		end
	end

	// read channel: one cycle to the answer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `SDMC_RESP_OKAY;
		end else if (arTake) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rdCtrl ? {29'h0, ctrl_q} : (rdStatus ? statusWord : 32'h0000_0000);
			rresp_q  <= (rdCtrl || rdStatus) ? `SDMC_RESP_OKAY : `SDMC_RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// sleep and wake sequencing
	logic [WW-1:0] wakeCnt_q; // cycles since wake request
	logic          awake_q;   // logic in normal operation
	wire           runRst = !rst_n || !awake_q; // core state held at its reset values

	// low request stops the core; wake completes inside the limit
	always_ff @(posedge clk) begin
		if (!rst_n || !wakeS) begin
			wakeCnt_q <= '0;
			awake_q   <= 1'b0;
		end else if (!awake_q) begin
			if (wakeCnt_q == WW'(WAKE_CYCLES - 1)) begin
				awake_q <= 1'b1;
			end else begin
				wakeCnt_q <= wakeCnt_q + WW'(1);
			end
		end
	end

	// chopper reference edges and on-phase divider
	logic          oscPrev_q; // reference level one cycle ago
	logic [DW-1:0] oscDiv_q;  // reference periods in the chopper period
	wire           oscRise   = oscS & ~oscPrev_q;
	wire           chopStart = oscRise & (oscDiv_q == '0);

	// divider of the reference into chopper periods
	always_ff @(posedge clk) begin
		if (runRst) begin
			oscPrev_q <= 1'b0;
			oscDiv_q  <= '0;
		end else begin
			oscPrev_q <= oscS;
			if (oscRise) begin
				oscDiv_q <= (oscDiv_q == DW'(CHOP_DIV - 1)) ? '0 : oscDiv_q + DW'(1);
			end
		end
	end

	// per pair position, direction and output decode
	sdmc_pkg::sdmc_bridge_t bridgeSt [4]; // requested state of each bridge
	logic [3:0]             posQ [2];     // electrical angle per pair
	logic [1:0]             mixed37;      // decay choice per pair
	logic [3:0]             maskVec;      // blanking active per bridge
	logic [3:0]             decayVec;     // decay phase per bridge

	for (genvar p = 0; p < 2; p++) begin : g_pair
		sdmc_pkg::sdmc_pair_pins_t pn;
		logic [3:0]                pos_q;    // angle in sixteenths of a cycle
		logic                      stepPrev_q; // step level one cycle ago
		logic                      enPrev_q;   // enable level one cycle ago
		logic                      pol_q;      // polarity caught at enable rise
		logic [3:0]                inc;        // step size for the resolution
		logic                      aPos, aNeg, bPos, bNeg;
		sdmc_pkg::sdmc_bridge_t    stepA, stepB, dcSt;

		assign pn   = pairS[p];
		wire stepRise = pn.stepPulse & ~stepPrev_q;
		wire enRise   = pn.outputOn & ~enPrev_q;
		wire holdInit = ~pn.resolutionSel0 & ~pn.resolutionSel1;

		// step size from the resolution selects
		assign inc = !pn.resolutionSel0 ? `SDMC_INC_HALF :
		             (pn.resolutionSel1 ? `SDMC_INC_QUARTER : `SDMC_INC_FULL);

		// angle counter, modulo one electrical cycle by the 4-bit width
		always_ff @(posedge clk) begin
			if (runRst) begin
				pos_q      <= `SDMC_POS_INIT;
				stepPrev_q <= 1'b0;
				enPrev_q   <= 1'b0;
				pol_q      <= 1'b1;
			end else begin
				stepPrev_q <= pn.stepPulse;
				enPrev_q   <= pn.outputOn;
				if (enRise) begin
					pol_q <= pn.rotationDir;
				end
				if (holdInit) begin
					pos_q <= `SDMC_POS_INIT;
				end else if (stepRise) begin
					pos_q <= pn.rotationDir ? pos_q + inc : pos_q - inc;
				end
			end
		end

		// coil signs from the angle
		assign aPos = (pos_q >= 4'hd) || (pos_q <= 4'h3);
		assign aNeg = (pos_q >= 4'h5) && (pos_q <= 4'hb);
		assign bPos = (pos_q >= 4'h1) && (pos_q <= 4'h7);
		assign bNeg = (pos_q >= 4'h9);

		// stepping decode: enable low is off, never brake
		assign stepA = !pn.outputOn ? sdmc_pkg::BR_OFF :
		               ((pol_q ? aPos : aNeg) ? sdmc_pkg::BR_FWD :
		               ((pol_q ? aNeg : aPos) ? sdmc_pkg::BR_REV : sdmc_pkg::BR_OFF));
		assign stepB = !pn.outputOn ? sdmc_pkg::BR_OFF :
		               ((pol_q ? bPos : bNeg) ? sdmc_pkg::BR_FWD :
		               ((pol_q ? bNeg : bPos) ? sdmc_pkg::BR_REV : sdmc_pkg::BR_OFF));

		// brushed decode: enable is the pwm and brake input
		assign dcSt = holdInit ? sdmc_pkg::BR_OFF :
		              (pn.resolutionSel0 && pn.resolutionSel1) ? sdmc_pkg::BR_BRAKE :
		              !pn.outputOn ? sdmc_pkg::BR_BRAKE :
		              (pn.resolutionSel0 ? sdmc_pkg::BR_FWD : sdmc_pkg::BR_REV);

		// fault or sleep forces both bridges off
		assign bridgeSt[2*p]   = (faultS || !awake_q) ? sdmc_pkg::BR_OFF :
		                         (dcMode[p] ? dcSt : stepA);
		assign bridgeSt[2*p+1] = (faultS || !awake_q) ? sdmc_pkg::BR_OFF :
		                         (dcMode[p] ? dcSt : stepB);

		// decay choice: limiter decay forces 37.5 percent
		wire pairDecay = decayVec[2*p] | decayVec[2*p+1];
		assign mixed37[p] = dcMode[p] ? pairDecay :
		                    (~pn.blankDecaySel | pairDecay);
		assign posQ[p] = pos_q;
	end

	// chopper phase and digital blanking per bridge
	for (genvar b = 0; b < 4; b++) begin : g_chop
		sdmc_pkg::sdmc_chop_state_t st_q;   // chopper phase
		logic [2:0]                 blank_q; // reference periods since on-phase start
		wire active = (bridgeSt[b] == sdmc_pkg::BR_FWD) || (bridgeSt[b] == sdmc_pkg::BR_REV);
		wire [2:0] target = (dcMode[b/2] && pairS[b/2].blankDecaySel) ?
		                    `SDMC_BLANK_DIGITAL : `SDMC_BLANK_NONE;
		wire masked = (blank_q < target);

		// on-phase with trips masked until blanking ends, then decay
		always_ff @(posedge clk) begin
			if (runRst) begin
				st_q    <= sdmc_pkg::CH_IDLE;
				blank_q <= 3'h0;
			end else begin
				case (st_q)
					sdmc_pkg::CH_IDLE: begin
						if (active && chopStart) begin
							st_q    <= sdmc_pkg::CH_ON;
							blank_q <= 3'h0;
						end
					end
					sdmc_pkg::CH_ON: begin
						if (!active) begin
							st_q <= sdmc_pkg::CH_IDLE;
						end else if (chopStart) begin
							blank_q <= 3'h0;
						end else if (masked) begin
							if (oscRise) begin
								blank_q <= blank_q + 3'h1;
							end
						end else if (tripS[b]) begin
							st_q <= sdmc_pkg::CH_DECAY;
						end
					end
					sdmc_pkg::CH_DECAY: begin
						if (!active) begin
							st_q <= sdmc_pkg::CH_IDLE;
						end else if (chopStart) begin
							st_q    <= sdmc_pkg::CH_ON;
							blank_q <= 3'h0;
						end
					end
					default: begin
						st_q <= sdmc_pkg::CH_IDLE;
					end
				endcase
			end
		end

		assign maskVec[b]  = (st_q == sdmc_pkg::CH_ON) & masked;
		assign decayVec[b] = (st_q == sdmc_pkg::CH_DECAY);
	end

	// leg commands with dead time
	for (genvar l = 0; l < 8; l++) begin : g_leg
		sdmc_pkg::sdmc_bridge_t  bs;
		sdmc_pkg::sdmc_leg_cmd_t lc;
		assign bs       = bridgeSt[l/2];
		assign lc.drive = (bs != sdmc_pkg::BR_OFF);
		assign lc.high  = (l % 2 == 0) ? (bs == sdmc_pkg::BR_FWD) : (bs == sdmc_pkg::BR_REV);

		sdmc_leg_drive #(
			.DEAD_CYCLES(DEAD_CYCLES)
		) u_leg (
			.clk   (clk),
			.rst_n (rst_n),
			.cmd   (lc),
			.hiGate(hiGate[l]),
			.loGate(loGate[l])
		);
	end

	// registered status outputs
	logic [3:0] maskOut_q;  // blanking flags
	logic [3:0] decayOut_q; // decay flags
	logic [1:0] mixOut_q;   // decay choice
	logic [1:0] monOut_q;   // angle at its initial position
	logic       fault_q;    // error seen

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			maskOut_q  <= 4'h0;
			decayOut_q <= 4'h0;
			mixOut_q   <= 2'h0;
			monOut_q   <= 2'h0;
			fault_q    <= 1'b0;
		end else begin
			maskOut_q  <= maskVec;
			decayOut_q <= decayVec;
			mixOut_q   <= mixed37;
			monOut_q   <= {posQ[1] == `SDMC_POS_INIT, posQ[0] == `SDMC_POS_INIT};
			fault_q    <= faultS;
		end
	end

	assign senseMask          = maskOut_q;
	assign decaying           = decayOut_q;
	assign mixedDecay37       = mixOut_q;
	assign positionMonitorOut = monOut_q;

	// open drain: only ever pulls low, during reset or on error
	assign faultOut = 1'b0;
	assign faultOe  = !rst_n | fault_q;

	// status view for the bus
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[`SDMC_STAT_POS1_LSB +: 4]  = posQ[0];
		statusWord[`SDMC_STAT_POS2_LSB +: 4]  = posQ[1];
		statusWord[`SDMC_STAT_FAULT_BIT]      = fault_q;
		statusWord[`SDMC_STAT_AWAKE_BIT]      = awake_q;
		statusWord[`SDMC_STAT_DECAY_LSB +: 2] = mixOut_q;
		statusWord[`SDMC_STAT_MASK_LSB +: 4]  = maskOut_q;
	end

endmodule

// ===== design/sdmc_defs.svh
// constants of the stepper and dc motor control logic: timing, register map, fields
`ifndef SDMC_DEFS_SVH
`define SDMC_DEFS_SVH

// clock and timing figures
`define SDMC_CLK_FREQ_KHZ     100000
`define SDMC_CLK_PERIOD_NS    10
`define SDMC_WAKE_TIME_MS     1
`define SDMC_DEAD_TIME_NS     200
`define SDMC_CHOP_DIV         16

// register byte addresses
`define SDMC_ADDR_CTRL        8'h00
`define SDMC_ADDR_STATUS      8'h04

// control register fields and reset value
`define SDMC_CTRL_DC_LSB      0
`define SDMC_CTRL_LOCK_BIT    2
`define SDMC_CTRL_RESET       3'h0

// status register fields
`define SDMC_STAT_POS1_LSB    0
`define SDMC_STAT_POS2_LSB    4
`define SDMC_STAT_FAULT_BIT   8
`define SDMC_STAT_AWAKE_BIT   9
`define SDMC_STAT_DECAY_LSB   10
`define SDMC_STAT_MASK_LSB    12

// electrical angle in sixteenths of a cycle
`define SDMC_POS_INIT         4'h2
`define SDMC_INC_FULL         4'h4
`define SDMC_INC_HALF         4'h2
`define SDMC_INC_QUARTER      4'h1

// digital blanking lengths in reference clock periods
`define SDMC_BLANK_DIGITAL    3'h4
`define SDMC_BLANK_NONE       3'h0

// bus answers
`define SDMC_RESP_OKAY        2'h0
`define SDMC_RESP_SLVERR      2'h2

`endif

// ===== design/sdmc_pkg.sv
// types shared by the motor control logic
package sdmc_pkg;

	// command to one half-bridge leg
	typedef struct packed {
		logic drive;   // leg conducts
		logic high;    // high side when set, low side otherwise
	} sdmc_leg_cmd_t;

	// pins of one channel pair
	typedef struct packed {
		logic stepPulse;
		logic outputOn;
		logic rotationDir;
		logic resolutionSel0;
		logic resolutionSel1;
		logic blankDecaySel;
	} sdmc_pair_pins_t;

	// state of one h-bridge
	typedef enum logic [3:0] {
		BR_OFF   = 4'h1,
		BR_FWD   = 4'h2,
		BR_REV   = 4'h4,
		BR_BRAKE = 4'h8
	} sdmc_bridge_t;

	// dead time sequencer of one leg
	typedef enum logic [1:0] {
		LEG_DEAD  = 2'h1,
		LEG_DRIVE = 2'h2
	} sdmc_leg_state_t;

	// chopper phase of one bridge
	typedef enum logic [2:0] {
		CH_IDLE  = 3'h1,
		CH_ON    = 3'h2,
		CH_DECAY = 3'h4
	} sdmc_chop_state_t;

endpackage

// ===== design/sdmc_pin_sync.sv
// three-stage synchroniser for pin inputs with agreement filter
`timescale 1ns/1ps
module sdmc_pin_sync #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// pins and filtered levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] stableOut
);

	if (WIDTH < 1) begin : g_badWidth
		$error("sdmc_pin_sync needs at least one bit");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_q;  // first stage, read only by the second
		logic s2_q;  // second stage
		logic s3_q;  // third stage
		logic out_q; // accepted level
		// change is taken once second and third stages agree
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				s1_q  <= 1'b0;
				s2_q  <= 1'b0;
				s3_q  <= 1'b0;
				out_q <= 1'b0;
			end else begin
				s1_q <= asyncIn[i];
				s2_q <= s1_q;
				s3_q <= s2_q;
				if (s2_q == s3_q) begin
					out_q <= s3_q;
				end
			end
		end
		assign stableOut[i] = out_q;
	end

endmodule

// ===== design/sdmc_leg_drive.sv
// one half-bridge leg with dead time inserted on every change
`timescale 1ns/1ps
module sdmc_leg_drive #(
	parameter int DEAD_CYCLES = 20
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// requested leg state
	input  wire sdmc_pkg::sdmc_leg_cmd_t cmd,
	// gate drives
	output logic                       hiGate,
	output logic                       loGate
);

	localparam int CW = $clog2(DEAD_CYCLES + 1);

	if (DEAD_CYCLES < 1) begin : g_badDead
		$error("sdmc_leg_drive needs a dead time of one cycle or more");
	end

	sdmc_pkg::sdmc_leg_state_t state_q;   // sequencer state
	sdmc_pkg::sdmc_leg_cmd_t   applied_q; // command being settled or driven
	logic [CW-1:0]             cnt_q;     // dead time counter
	logic                      hi_q;      // high gate flop
	logic                      lo_q;      // low gate flop

	// decode of the applied command
	wire changed = (cmd != applied_q);
	wire hiNext  = applied_q.drive & applied_q.high;
	wire loNext  = applied_q.drive & ~applied_q.high;
	wire deadEnd = (cnt_q == CW'(DEAD_CYCLES - 1));

	// both gates off for the dead time before any new state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q   <= sdmc_pkg::LEG_DEAD;
			applied_q <= '0;
			cnt_q     <= '0;
			hi_q      <= 1'b0;
			lo_q      <= 1'b0;
		end else begin
			case (state_q)
				sdmc_pkg::LEG_DRIVE: begin
					if (changed) begin
						state_q   <= sdmc_pkg::LEG_DEAD;
						applied_q <= cmd;
						cnt_q     <= '0;
						hi_q      <= 1'b0;
						lo_q      <= 1'b0;
					end
				end
				sdmc_pkg::LEG_DEAD: begin
					if (changed) begin
						applied_q <= cmd;
						cnt_q     <= '0;
					end else if (deadEnd) begin
						state_q <= sdmc_pkg::LEG_DRIVE;
						hi_q    <= hiNext;
						lo_q    <= loNext;
					end else begin
						cnt_q <= cnt_q + CW'(1);
					end
				end
				default: begin
					state_q <= sdmc_pkg::LEG_DEAD;
					hi_q    <= 1'b0;
					lo_q    <= 1'b0;
				end
			endcase
		end
	end

	assign hiGate = hi_q;
	assign loGate = lo_q;

endmodule

// ===== verification/sdmc_checker.sv
// port assertions of the motor control top
`timescale 1ns/1ps
module sdmc_checker (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// bus handshakes
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wvalid,
	input wire logic       wready,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic       arvalid,
	input wire logic       rvalid,
	input wire logic       rready,
	// pins and drives
	input wire logic       wakeRequest,
	input wire logic       thermalShutdown,
	input wire logic       overcurrentDetect,
	input wire logic [7:0] hiGate,
	input wire logic [7:0] loGate,
	input wire logic       faultOut,
	input wire logic       faultOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	gate_overlap_a: assert property ((hiGate & loGate) == 8'h00)
		else $error("both switches of a leg on");
	dead_gap_a: assert property ($fell(hiGate[4]) |-> !loGate[4] [*2])
		else $error("no dead time on leg four");
	fault_sink_a: assert property ((thermalShutdown || overcurrentDetect) [*8] |-> faultOe)
		else $error("fault pin not pulled low");
	fault_release_a: assert property ((!thermalShutdown && !overcurrentDetect) [*8] |-> !faultOe)
		else $error("fault pin held low without error");
	fault_level_a: assert property (faultOe |-> faultOut == 1'b0)
		else $error("fault pin driven high");
	sleep_off_a: assert property ((!wakeRequest) [*8] |-> ##[0:8] (hiGate | loGate) == 8'h00)
		else $error("gates on while asleep");
	write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write answer late");
	write_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write answer dropped");
	read_answer_a: assert property (arvalid && !rvalid |=> rvalid)
		else $error("read answer late");
	read_hold_a: assert property (rvalid && !rready |=> rvalid)
		else $error("read answer dropped");
endmodule

// ===== verification/sdmc_step_host.sv
// step pulse source standing in for the controlling host
`timescale 1ns/1ps
module sdmc_step_host (
	// clock and burst request
	input  wire logic       clk,
	input  wire logic       start,
	input  wire logic [7:0] pulses,
	input  wire logic       slow,
	// step pin and progress
	output logic            stepPulse,
	output logic            busy
);
	logic [7:0] left_q = 0; // pulses still to finish, counted down at each falling edge
	logic [4:0] cnt_q = 0;  // half pulse timer
	initial stepPulse = 0;
	initial busy = 0;
	// half pulses of 6 or 20 cycles stay well above the input filter depth
	always @(posedge clk) begin
		cnt_q <= cnt_q + 5'h1;
		if (start) begin
			{left_q, busy, cnt_q} <= {pulses, 1'b1, 5'h0};
		end else if (busy && cnt_q == (slow ? 5'd19 : 5'd5)) begin
			cnt_q <= 5'h0;
			stepPulse <= ~stepPulse;
			if (stepPulse) {left_q, busy} <= {left_q - 8'h1, left_q != 8'h1};
		end
	end
endmodule

// ===== verification/sdmc_tb.sv
// self-checking bench of the motor control top
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0, pulses = 0;
	logic [31:0] wdata = 0, lf = 32'h40d0d236;
	logic [4:0] p1 = 0; // pair1 pins, enable low at power-up
	logic [5:0] p2 = 6'h01;
	logic refClk = 0, wake = 1, therm = 0, ocd = 0, probe = 0, start = 0, slow = 0;
	logic [3:0] pos = 4'h2, trip = 0, strb = 4'hf;
	wire awready, wready, bvalid, arready, rvalid, faultOut, faultOe, step, busy;
	wire [1:0] bresp, rresp, mix, mon;
	wire [3:0] smask, dec;
	wire [31:0] rdata;
	wire [7:0] hiGate, loGate;
	wire alert = faultOe ? faultOut : 1'b1; // pulled-up pin level
	logic [65:0] notes[$]; // mask, response, data
	int failures = 0, check_count = 0;
	logic [4:0] md[5] = '{5'h0c, 5'h04, 5'h0a, 5'h0e, 5'h08};
	logic [3:0] inc[5] = '{4'h4, 4'hc, 4'h2, 4'h1, 4'h0};
	logic [2:0] cd[6] = '{3'h7, 3'h3, 3'h2, 3'h5, 3'h4, 3'h1};
	logic [31:0] ce[6] = '{32'h30, 32'h2010, 32'h30, 32'h1020, 32'h30, 32'h0};
	always #5 clk = ~clk;
	always #40 refClk = ~refClk;
	sdmc_step_host host_u (.clk(clk), .start(start), .pulses(pulses), .slow(slow),
		.stepPulse(step), .busy(busy));
	sdmc_top #(.WAKE_CYCLES(8), .DEAD_CYCLES(2), .CHOP_DIV(6)) dut_u (
		.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awprot({3{slow}}), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot({3{slow}}),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pairPins({p2, step, p1}), .senseTrip(trip), .chopperRefClock(refClk),
		.wakeRequest(wake), .thermalShutdown(therm), .overcurrentDetect(ocd), .hiGate(hiGate),
		.loGate(loGate), .senseMask(smask), .decaying(dec), .mixedDecay37(mix),
		.positionMonitorOut(mon), .faultOut(faultOut), .faultOe(faultOe));
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic check(input logic [33:0] s, input logic [33:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", probe ? "pins" : "bus", e, s);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		notes.push_back({32'h0, r, 32'h0});
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		fork
			begin do @(posedge clk); while (!awready); awvalid <= 0; end
			begin do @(posedge clk); while (!wready); wvalid <= 0; end
		join
		do @(posedge clk); while (!bvalid);
		bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
		notes.push_back({m, r, e});
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge clk); while (!arready);
		arvalid <= 0;
		do @(posedge clk); while (!rvalid);
		rready <= 0;
	endtask
	// ask the watcher to sample the pin and gate levels
	task automatic look(input logic [65:0] n);
		notes.push_back(n);
		probe <= 1;
		@(posedge clk);
		probe <= 0;
		@(posedge clk);
	endtask
	task automatic steps(input logic [7:0] n);
		{pulses, start} <= {n, 1'b1};
		@(posedge clk);
		start <= 0;
		do @(posedge clk); while (busy);
		repeat (8) @(posedge clk);
	endtask
	// watcher: compares each answer with the oldest note
	always @(posedge clk) begin : watch
		logic [65:0] n;
		if ((rvalid && rready) || (bvalid && bready) || probe) begin
			n = notes.pop_front();
			check((rvalid && rready ? {rresp, rdata} : bvalid && bready ? {bresp, 32'h0} :
				{3'h0, mix, mon, dec, smask, alert, hiGate, loGate}) & {2'h3, n[65:34]}, n[33:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		repeat (20) @(posedge clk);
		rd(8'h04, 32'hc0f, 32'h402, 2'h0);
		for (int i = 0; i < 5; i++) begin
			lf = nx(lf);
			{p1, slow, trip} <= {md[i], lf[3], lf[7:4]};
			steps({5'h0, lf[2:0]} + 8'h1);
			pos = i == 4 ? 4'h2 : pos + 4'(inc[i] * ({1'b0, lf[2:0]} + 4'h1));
			rd(8'h04, 32'hf, {28'h0, pos}, 2'h0);
		end
		for (int d = 1; d >= 0; d--) begin
			p1 <= {1'b0, d[0], 3'h0};
			repeat (12) @(posedge clk);
			look({32'h1e000f0f, 2'h0, 32'h0e000000});
			p1 <= {1'b1, d[0], 3'h0};
			repeat (80) @(posedge clk);
			look({32'h1e000f0f, 2'h0, d ? 32'h0e00050a : 32'h0e000a05});
		end
		wr(8'h04, 32'h0, 2'h2);
		rd(8'h08, 32'hffffffff, 32'h0, 2'h2);
		strb <= 4'he;
		wr(8'h00, 32'h3, 2'h0);
		strb <= 4'hf;
		rd(8'h00, 32'h7, 32'h0, 2'h0);
		wr(8'h00, 32'h2, 2'h0);
		for (int i = 0; i < 6; i++) begin
			p2 <= {1'b0, cd[i][0], 1'b0, cd[i][2:1], 1'b0};
			repeat (80) @(posedge clk);
			look({32'h3030, 2'h0, ce[i]});
		end
		for (int f = 0; f < 2; f++) begin
			{therm, ocd} <= f ? 2'b01 : 2'b10;
			repeat (12) @(posedge clk);
			look({32'h1fffffff, 2'h0, 32'h0e000000});
			rd(8'h04, 32'h100, 32'h100, 2'h0);
			{therm, ocd} <= 2'b00;
			repeat (12) @(posedge clk);
			rd(8'h04, 32'h100, 32'h0, 2'h0);
		end
		wake <= 0;
		repeat (20) @(posedge clk);
		look({32'h1fffffff, 2'h0, 32'h0e010000});
		wake <= 1;
		repeat (30) @(posedge clk);
		rd(8'h04, 32'h20f, 32'h202, 2'h0);
		final_report();
	end
endmodule
bind sdmc_top sdmc_checker chk_u (.clk(clk), .rst_n(rst_n), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .rvalid(rvalid), .rready(rready), .wakeRequest(wakeRequest),
	.thermalShutdown(thermalShutdown), .overcurrentDetect(overcurrentDetect),
	.hiGate(hiGate), .loGate(loGate), .faultOut(faultOut), .faultOe(faultOe));
